// >>> logic/pause_cfg_pkg.sv
// constants and types shared by the port flow control register block
// Notes on behaviour
// - bit 6 enables half-duplex backpressure
// - bit 5 reads duplex, 1 means half
// - bit 4 reads receive pause in effect
// - bit 3 reads transmit pause in effect
// - bit 2 receive enable used when manual/no-autoneg
// - bit 1 transmit enable used when manual/no-autoneg
// - auto mode with autoneg uses negotiated result
// - auto mode without autoneg uses written bits
// - manual mode applies written bits in full duplex
// - status bits show settings actually in effect
// - writes never touch phy advertisement values
// - writable defaults come from straps at reset
// - loader rewrite of straps updates fields
// - status defaults derive from several straps
package pause_cfg_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam logic [11:0] FLOW_CTRL_OFFSET = 12'h1A4; // port2_flow_control
	localparam int BIT_BACKPRESSURE = 6;
	localparam int BIT_CUR_DUPLEX = 5;
	localparam int BIT_CUR_RX = 4;
	localparam int BIT_CUR_TX = 3;
	localparam int BIT_RX_EN = 2;
	localparam int BIT_TX_EN = 1;
	localparam int BIT_MANUAL = 0;
	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
	// resolution of the effective pause settings
	typedef enum {SRC_AUTONEG, SRC_WRITTEN, SRC_HALF} pause_src_t;
endpackage

// >>> logic/pause_resolve.sv
// combinational choice of effective pause enables
`timescale 1ns/10ps
module pause_resolve
	import pause_cfg_pkg::*;
(
	pause_resolve_if.resolver r
);
	pause_src_t src; // which source governs
	// full-duplex pause never applies on a half-duplex link
	always_comb begin
		if (r.half) begin
			src = SRC_HALF;
		end else if (!r.manual && r.an_enable) begin
			src = SRC_AUTONEG;
		end else begin
			src = SRC_WRITTEN;
		end
	end
	// drive enables from the chosen source
	always_comb begin
		case (src)
			SRC_AUTONEG: begin
				r.eff_rx = r.an_rx;
				r.eff_tx = r.an_tx;
			end
			SRC_WRITTEN: begin
				r.eff_rx = r.rx_en;
				r.eff_tx = r.tx_en;
			end
			default: begin
				r.eff_rx = 1'b0;
				r.eff_tx = 1'b0;
			end
		endcase
	end
endmodule // pause_resolve

// >>> logic/pause_resolve_if.sv
// interface carrying settings into the pause resolver and its answers back
`timescale 1ns/10ps
interface pause_resolve_if;
	logic manual; // manual select bit
	logic rx_en; // written receive enable
	logic tx_en; // written transmit enable
	logic an_enable; // autoneg enabled
	logic an_rx; // negotiated receive pause
	logic an_tx; // negotiated transmit pause
	logic half; // link is half duplex
	logic eff_rx; // receive pause in effect
	logic eff_tx; // transmit pause in effect
	modport ctrl (output manual, rx_en, tx_en, an_enable, an_rx, an_tx, half,
		input eff_rx, eff_tx);
	modport resolver (input manual, rx_en, tx_en, an_enable, an_rx, an_tx, half,
		output eff_rx, eff_tx);
endinterface // pause_resolve_if

// >>> logic/port_flow_control_select.sv
// port flow control select register with live status read back
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/10ps
module port_flow_control_select
	import pause_cfg_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic clk_en, // freezes all state while low
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [DATA_W-1:0] rdata,
	input wire logic backpressure_default_strap, // strap values as held by strap logic
	input wire logic full_duplex_pause_strap,
	input wire logic manual_select_strap,
	input wire logic strap_reload, // pulse: loader rewrote the straps
	input wire logic autoneg_enable, // from the phy
	input wire logic an_rx_pause, // negotiated result
	input wire logic an_tx_pause,
	input wire logic link_half_duplex, // duplex in effect, 1 = half
	output logic backpressure_enable,
	output logic current_duplex,
	output logic current_rx_pause_enable,
	output logic current_tx_pause_enable
);
	// how the block hangs together
	// - four writable fields: backpressure, receive pause, transmit pause,
	//   manual select; each sits in its own flop and reads back unchanged
	// - three read-only status bits: duplex, receive pause in effect and
	//   transmit pause in effect
	// - status is a registered copy of the resolver output and link duplex, one enabled edge
	//   behind the phy and field inputs; this costs a cycle of latency but
	//   keeps the status pins free of glitches from the resolver mux
	// - half duplex forces both pause bits off, since full-duplex pause frames
	//   have no meaning on a shared link; backpressure covers that case
	// - straps reach the writable fields on the first enabled edge after
	//   reset and again whenever the loader pulses strap_reload
	// - a strap load beats a software write in the same cycle, so the strap
	//   image can never be half overwritten by a racing bus access
	// - status defaults follow from the strap-loaded fields through the
	//   resolver, so they combine several straps rather than copy one
	// - the phy advertisement register lives elsewhere; nothing here writes it
	// - clk_en low freezes every flop, the read data register included, so
	//   a read answered just before a freeze keeps standing until it lifts
	// - strap and phy inputs are taken as levels of this clock domain;
	//   whoever drives them from another domain must synchronise them first
	// - reserved bits are never stored, which keeps them at zero for free
	// - a write in the very first enabled cycle after reset is lost to the
	//   strap capture; software should wait one cycle before its first access
	//
	// field and status flops
	logic backpressure_q; // writable fields
	logic rx_pause_enable_q;
	logic tx_pause_enable_q;
	logic manual_pause_select_q;
	logic dup_q; // status snapshot bits
	logic cur_rx_q;
	logic cur_tx_q;
	logic load_q; // strap capture pending after reset
	logic [DATA_W-1:0] rdata_q;
	logic hit; // address decode
	pause_resolve_if rif();

	assign hit = (addr == FLOW_CTRL_OFFSET);

	// resolver inputs: register fields and phy state
	assign rif.manual = manual_pause_select_q;
	assign rif.rx_en = rx_pause_enable_q;
	assign rif.tx_en = tx_pause_enable_q;
	assign rif.an_enable = autoneg_enable;
	assign rif.an_rx = an_rx_pause;
	assign rif.an_tx = an_tx_pause;
	assign rif.half = link_half_duplex;

	pause_resolve u_resolve (
		.r(rif.resolver)
	);

	// strap capture flag: set during reset, consumed on first enabled edge
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			load_q <= 1'b1;
		end else if (clk_en) begin
			load_q <= 1'b0;
		end
	end

	// writable fields: strap loads win over a software write in the same cycle
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			backpressure_q <= 1'b0;
			rx_pause_enable_q <= 1'b0;
			tx_pause_enable_q <= 1'b0;
			manual_pause_select_q <= 1'b0;
		end else if (clk_en) begin
			if (load_q || strap_reload) begin
				backpressure_q <= backpressure_default_strap;
				rx_pause_enable_q <= full_duplex_pause_strap;
				tx_pause_enable_q <= full_duplex_pause_strap;
				manual_pause_select_q <= manual_select_strap;
			end else if (wr_stb && hit) begin
				// only this block's fields change; phy advertisement is untouched
				backpressure_q <= wdata[BIT_BACKPRESSURE];
				rx_pause_enable_q <= wdata[BIT_RX_EN];
				tx_pause_enable_q <= wdata[BIT_TX_EN];
				manual_pause_select_q <= wdata[BIT_MANUAL];
			end
		end
	end

	// status: registered copy of what is in effect, fed from the resolver and the link duplex
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			dup_q <= 1'b0;
			cur_rx_q <= 1'b0;
			cur_tx_q <= 1'b0;
		end else if (clk_en) begin
			dup_q <= link_half_duplex;
			cur_rx_q <= rif.eff_rx;
			cur_tx_q <= rif.eff_tx;
		end
	end

	// read port: data in the cycle after the strobe, zero after every other enabled edge
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			rdata_q <= UNMAPPED_READ;
		end else if (clk_en) begin
			rdata_q <= UNMAPPED_READ;
			if (rd_stb && hit) begin
				rdata_q[BIT_BACKPRESSURE] <= backpressure_q;
				rdata_q[BIT_CUR_DUPLEX] <= dup_q;
				rdata_q[BIT_CUR_RX] <= cur_rx_q;
				rdata_q[BIT_CUR_TX] <= cur_tx_q;
				rdata_q[BIT_RX_EN] <= rx_pause_enable_q;
				rdata_q[BIT_TX_EN] <= tx_pause_enable_q;
				rdata_q[BIT_MANUAL] <= manual_pause_select_q;
			end
		end
	end

	assign rdata = rdata_q;
	assign backpressure_enable = backpressure_q;
	assign current_duplex = dup_q;
	assign current_rx_pause_enable = cur_rx_q;
	assign current_tx_pause_enable = cur_tx_q;

	// checks
	// each check below is disabled while reset is low and, except chk_reset_values, looks one
	// edge ahead of the cycle that satisfies its named step; clk_en is part of
	// every step, since a frozen edge moves nothing and is checked apart
	// expectations come from the inputs and fields of the previous cycle,
	// never from the read data itself, so a stuck read port cannot hide
	// a stuck field
	//
	// named steps that the checks below are built from; the checks run only
	// while out of reset, and all but chk_reset_values look one clock edge ahead
	// a software write that no strap load overrides
	sequence seq_write_hit;
		clk_en && wr_stb && hit && !load_q && !strap_reload;
	endsequence
	// a software write to some other address
	sequence seq_write_miss;
		clk_en && wr_stb && !hit && !load_q && !strap_reload;
	endsequence
	// a read strobe at this register
	sequence seq_read_hit;
		clk_en && rd_stb && hit;
	endsequence
	// a read strobe at any other address
	sequence seq_read_miss;
		clk_en && rd_stb && !hit;
	endsequence
	// straps copied into the fields, after reset or on a loader pulse
	sequence seq_strap_load;
		clk_en && (load_q || strap_reload);
	endsequence
	// auto mode with autoneg on, full-duplex link
	sequence seq_auto_full;
		clk_en && !manual_pause_select_q && autoneg_enable && !link_half_duplex;
	endsequence
	// written bits govern, full-duplex link
	sequence seq_written_full;
		clk_en && (manual_pause_select_q || !autoneg_enable) && !link_half_duplex;
	endsequence
	// manual select on, full-duplex link
	sequence seq_manual_full;
		clk_en && manual_pause_select_q && !link_half_duplex;
	endsequence
	// clock enable low: nothing may move
	sequence seq_frozen;
		!clk_en;
	endsequence

	// which source drives the status bits
	// the resolver is pure logic; all checks here but chk_status_eff see its choice
	// only through the status flops one enabled edge later
	// auto mode with autoneg follows negotiated result one cycle on
	chk_auto_follows_an: assert property (@(posedge clk_sys) disable iff (!reset_n)
		seq_auto_full |=> current_rx_pause_enable == $past(an_rx_pause))
		else $error("autoneg rx not followed");

	// same for the transmit side
	chk_auto_tx: assert property (@(posedge clk_sys) disable iff (!reset_n)
		seq_auto_full |=> current_tx_pause_enable == $past(an_tx_pause))
		else $error("autoneg tx not followed");

	// written transmit bit governs when manual or autoneg off
	chk_written_used: assert property (@(posedge clk_sys) disable iff (!reset_n)
		seq_written_full |=> current_tx_pause_enable == $past(tx_pause_enable_q))
		else $error("written tx not used");

	// written receive bit governs in the same case
	chk_written_rx: assert property (@(posedge clk_sys) disable iff (!reset_n)
		seq_written_full |=> current_rx_pause_enable == $past(rx_pause_enable_q))
		else $error("written rx not used");

	// manual select keeps both written bits in force whatever autoneg says
	chk_manual_both: assert property (@(posedge clk_sys) disable iff (!reset_n)
		seq_manual_full |=> current_rx_pause_enable == $past(rx_pause_enable_q)
		&& current_tx_pause_enable == $past(tx_pause_enable_q))
		else $error("manual select ignored");

	// duplex status mirrors the link one cycle on
	chk_duplex_status: assert property (@(posedge clk_sys) disable iff (!reset_n)
		clk_en |=> current_duplex == $past(link_half_duplex)) else $error("duplex status wrong");

	// half duplex blocks full-duplex pause in both directions
	chk_half_no_pause: assert property (@(posedge clk_sys) disable iff (!reset_n)
		clk_en && link_half_duplex |=> !current_rx_pause_enable && !current_tx_pause_enable)
		else $error("pause in half duplex");

	// status bits register what the resolver chose
	chk_status_eff: assert property (@(posedge clk_sys) disable iff (!reset_n)
		clk_en |=> current_rx_pause_enable == $past(rif.eff_rx)
		&& current_tx_pause_enable == $past(rif.eff_tx))
		else $error("status lost resolver output");

	// register fields
	// a write that lands must show in the field the next cycle; a write
	// that lost to a strap load is left to the strap checks further down
	// software write reaches the backpressure pin one cycle on
	chk_write_bp: assert property (@(posedge clk_sys) disable iff (!reset_n)
		seq_write_hit |=> backpressure_enable == $past(wdata[BIT_BACKPRESSURE]))
		else $error("bp write lost");

	// software write reaches the receive enable
	chk_write_rx: assert property (@(posedge clk_sys) disable iff (!reset_n)
		seq_write_hit |=> rx_pause_enable_q == $past(wdata[BIT_RX_EN]))
		else $error("rx enable write lost");

	// software write reaches the transmit enable
	chk_write_tx: assert property (@(posedge clk_sys) disable iff (!reset_n)
		seq_write_hit |=> tx_pause_enable_q == $past(wdata[BIT_TX_EN]))
		else $error("tx enable write lost");

	// software write reaches the manual select
	chk_write_manual: assert property (@(posedge clk_sys) disable iff (!reset_n)
		seq_write_hit |=> manual_pause_select_q == $past(wdata[BIT_MANUAL]))
		else $error("manual write lost");

	// writes elsewhere leave every field alone
	chk_miss_write: assert property (@(posedge clk_sys) disable iff (!reset_n)
		seq_write_miss |=> $stable(backpressure_q) && $stable(rx_pause_enable_q)
		&& $stable(tx_pause_enable_q) && $stable(manual_pause_select_q))
		else $error("foreign write changed a field");

	// strap loads
	// the loader may pulse at any time, also on top of a bus write, and
	// the capture after reset must happen exactly once
	// loader pulse reloads backpressure
	chk_reload_bp: assert property (@(posedge clk_sys) disable iff (!reset_n)
		clk_en && strap_reload |=> backpressure_q == $past(backpressure_default_strap))
		else $error("reload not applied");

	// any strap load sets the pause enables and manual select from straps
	chk_strap_fields: assert property (@(posedge clk_sys) disable iff (!reset_n)
		seq_strap_load |=> rx_pause_enable_q == $past(full_duplex_pause_strap)
		&& tx_pause_enable_q == $past(full_duplex_pause_strap)
		&& manual_pause_select_q == $past(manual_select_strap))
		else $error("strap load missed a field");

	// a loader pulse wins over a write in the same cycle
	chk_load_beats_write: assert property (@(posedge clk_sys) disable iff (!reset_n)
		clk_en && strap_reload && wr_stb && hit |=> backpressure_q == $past(backpressure_default_strap))
		else $error("write beat strap load");

	// strap capture happens once, on the first enabled edge after reset
	chk_load_once: assert property (@(posedge clk_sys) disable iff (!reset_n)
		clk_en && load_q |=> !load_q) else $error("strap capture repeated");

	// first cycle out of reset: outputs still at their reset values
	chk_reset_values: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$rose(reset_n) |-> !backpressure_enable && !current_duplex
		&& !current_rx_pause_enable && !current_tx_pause_enable && load_q && rdata == UNMAPPED_READ)
		else $error("reset values wrong");

	// read port
	// data stand in the cycle after the strobe and through any freeze that follows; every
	// other enabled cycle the port rests at zero so a late sampler reads nothing stale
	// reserved bits read zero on every read
	chk_reserved_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
		rd_stb && clk_en |=> rdata[31:7] == 25'h0) else $error("reserved bits nonzero");

	// reads elsewhere return zero
	chk_miss_read: assert property (@(posedge clk_sys) disable iff (!reset_n)
		seq_read_miss |=> rdata == UNMAPPED_READ) else $error("foreign read not zero");

	// outside the answer cycle the read data rest at zero
	chk_idle_read: assert property (@(posedge clk_sys) disable iff (!reset_n)
		clk_en && !rd_stb |=> rdata == UNMAPPED_READ) else $error("read data not idle");

	// manual select read back
	chk_read_manual: assert property (@(posedge clk_sys) disable iff (!reset_n)
		seq_read_hit |=> rdata[BIT_MANUAL] == $past(manual_pause_select_q))
		else $error("manual readback wrong");

	// writable fields read back as stored
	chk_read_fields: assert property (@(posedge clk_sys) disable iff (!reset_n)
		seq_read_hit |=> rdata[BIT_BACKPRESSURE] == $past(backpressure_q)
		&& rdata[BIT_RX_EN] == $past(rx_pause_enable_q)
		&& rdata[BIT_TX_EN] == $past(tx_pause_enable_q))
		else $error("field readback wrong");

	// status bits read back as registered
	chk_read_status: assert property (@(posedge clk_sys) disable iff (!reset_n)
		seq_read_hit |=> rdata[BIT_CUR_DUPLEX] == $past(dup_q)
		&& rdata[BIT_CUR_RX] == $past(cur_rx_q)
		&& rdata[BIT_CUR_TX] == $past(cur_tx_q))
		else $error("status readback wrong");

	// freeze
	// a low clock enable must hold every flop, including the capture flag,
	// otherwise the strap load could slip past a frozen first edge
	// clock enable low holds the writable fields
	chk_freeze_fields: assert property (@(posedge clk_sys) disable iff (!reset_n)
		seq_frozen |=> $stable(backpressure_q) && $stable(rx_pause_enable_q)
		&& $stable(tx_pause_enable_q) && $stable(manual_pause_select_q))
		else $error("field moved while frozen");

	// clock enable low holds status, read data and the capture flag
	chk_freeze_status: assert property (@(posedge clk_sys) disable iff (!reset_n)
		seq_frozen |=> $stable(dup_q) && $stable(cur_rx_q) && $stable(cur_tx_q)
		&& $stable(rdata_q) && $stable(load_q))
		else $error("status moved while frozen");
endmodule // port_flow_control_select

// >>> sim/phy_mac_model.sv
// far side model: phy autoneg result and mac duplex as seen by the port
`timescale 1ns/10ps
module phy_mac_model (
	input wire logic clk_sys,
	input wire logic [3:0] cmd, // autoneg, an rx, an tx, half
	output logic autoneg_enable,
	output logic an_rx_pause,
	output logic an_tx_pause,
	output logic link_half_duplex
);
	// levels change one clock after the bench asks, like a real link update
	always_ff @(posedge clk_sys) begin
		{autoneg_enable, an_rx_pause, an_tx_pause, link_half_duplex} <= cmd;
	end
endmodule // phy_mac_model

// >>> sim/tb_top.sv
// self-checking bench for the port flow control select register
`timescale 1ns/10ps
module tb_top;
	import pause_cfg_pkg::*;
	logic clk_sys = 0, reset_n = 0, clk_en = 1, wr_stb = 0, rd_stb = 0, reload = 0;
	logic [ADDR_W-1:0] addr = '0;
	logic [DATA_W-1:0] wdata = '0, rdata, got, w;
	logic [2:0] strap = '0; // backpressure, full duplex pause, manual
	logic [3:0] cmd = '0; // autoneg, an rx, an tx, half
	logic an, arx, atx, half, bp_o, dup_o, crx_o, ctx_o;
	logic [3:0] fld; // expected bits 6,2,1,0
	int errors = 0, n_checks = 0, cyc = 0, k;
	always #25 clk_sys = ~clk_sys;
	phy_mac_model u_phy_mac_model (.clk_sys(clk_sys), .cmd(cmd), .autoneg_enable(an),
		.an_rx_pause(arx), .an_tx_pause(atx), .link_half_duplex(half));
	port_flow_control_select u_port_flow_control_select (.clk_sys(clk_sys), .reset_n(reset_n),
		.clk_en(clk_en), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
		.rdata(rdata), .backpressure_default_strap(strap[2]), .full_duplex_pause_strap(strap[1]),
		.manual_select_strap(strap[0]), .strap_reload(reload), .autoneg_enable(an),
		.an_rx_pause(arx), .an_tx_pause(atx), .link_half_duplex(half),
		.backpressure_enable(bp_o), .current_duplex(dup_o),
		.current_rx_pause_enable(crx_o), .current_tx_pause_enable(ctx_o));
	// expected word: half duplex kills pause, auto mode with autoneg takes the result
	function automatic logic [31:0] expect_word(logic [3:0] f, logic [3:0] c);
		logic rx, tx;
		rx = c[0] ? 1'b0 : (!f[0] && c[3]) ? c[2] : f[2];
		tx = c[0] ? 1'b0 : (!f[0] && c[3]) ? c[1] : f[1];
		return {25'h0, f[3], c[0], rx, tx, f[2], f[1], f[0]};
	endfunction
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			$display("BAD %s exp %h got %h", n, e, g);
			errors++;
		end
	endtask
	task automatic summarize();
		if (errors == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic wr(logic [11:0] a, logic [31:0] d);
		@(posedge clk_sys);
		addr <= a; wdata <= d; wr_stb <= 1;
		@(posedge clk_sys);
		wr_stb <= 0;
	endtask
	// read data stand in the cycle after the strobe, and longer only while clk_en is low
	task automatic rd(logic [11:0] a);
		@(posedge clk_sys);
		addr <= a; rd_stb <= 1;
		@(posedge clk_sys);
		rd_stb <= 0;
		#1 got = rdata;
	endtask
	task automatic check();
		logic [31:0] e;
		repeat (2) @(posedge clk_sys);
		e = expect_word(fld, cmd);
		rd(FLOW_CTRL_OFFSET);
		chk("word", e, got);
		chk("pins", {28'h0, fld[3], cmd[0], e[4], e[3]}, {28'h0, bp_o, dup_o, crx_o, ctx_o});
	endtask
	// hang guard: the run needs well under this many cycles
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			summarize();
		end
	end
	initial begin
		void'($urandom(78101));
		strap = 3'($urandom);
		cmd = 4'($urandom);
		repeat (4) @(posedge clk_sys);
		reset_n <= 1;
		fld = {strap[2], strap[1], strap[1], strap[0]};
		check();
		for (int i = 0; i < 60; i++) begin
			k = $urandom_range(0, 7);
			@(posedge clk_sys);
			cmd <= 4'($urandom);
			strap <= 3'($urandom); // held straps alone must not move the fields
			if (k == 0) wr(12'h1A0, $urandom);
			else if (k == 1) begin
				// loader update collides with a write: straps must win
				@(posedge clk_sys);
				reload <= 1; wr_stb <= 1; addr <= FLOW_CTRL_OFFSET; wdata <= $urandom;
				@(posedge clk_sys);
				reload <= 0; wr_stb <= 0;
				fld = {strap[2], strap[1], strap[1], strap[0]};
			end else begin
				w = $urandom;
				wr(FLOW_CTRL_OFFSET, w);
				fld = {w[6], w[2], w[1], w[0]};
			end
			check();
		end
		// frozen clock enable: a write in that time must not land
		@(posedge clk_sys);
		clk_en <= 0;
		wr(FLOW_CTRL_OFFSET, ~{25'h0, fld[3], 3'h0, fld[2], fld[1], fld[0]});
		@(posedge clk_sys);
		clk_en <= 1;
		check();
		// mid-run reset captures the straps again
		@(posedge clk_sys);
		strap <= 3'($urandom);
		reset_n <= 0;
		repeat (2) @(posedge clk_sys);
		reset_n <= 1;
		fld = {strap[2], strap[1], strap[1], strap[0]};
		check();
		rd(12'h1A8);
		chk("unmapped", 32'h0, got);
		summarize();
	end
endmodule // tb_top
